// File: hdl/erfhp_pkg.sv
// Contract
// - mac words stored, write pointer advances
// - one status word per frame, separate fifo
// - fill register shows data and status counts
// - status and data read independently
// - read of empty fifo raises error flag
// - packet start shifted by 0-31 bytes
// - pad packet to whole burst multiple
// - offset and padding applied per packet
// - skip bit jumps read pointer past packet
// - skip self-clears, status fifo untouched
// - flush resets all receive fifo pointers
// - flush bit self-clears when done
// - 32-bit words read as atomic units
// - status holds length, filter, broadcast fields
// - status bit 15 ors bits 11,7,6,1
// - receiver halted event pulses after halt
// - status fifo overrun raises error flag
// - status bit 7 marks frames over 1518
package erfhp_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_RX_DATA = 8'h00; // data fifo read port
  localparam logic [7:0] ADDR_RX_STAT = 8'h04; // status fifo read port
  localparam logic [7:0] ADDR_FILL = 8'h08; // rx_fifo_fill_info
  localparam logic [7:0] ADDR_RX_CFG = 8'h0C; // receive configuration
  localparam logic [7:0] ADDR_DP_CTRL = 8'h10; // rx_datapath_control
  localparam logic [7:0] ADDR_MAC_CTRL = 8'h14; // receiver enable / halted
  localparam logic [7:0] ADDR_ERR = 8'h18; // receive_error_flag
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_OFS_LSB = 0; // 5-bit start offset
  localparam int CFG_PAD_BIT = 7; // end padding enable
  localparam int CFG_BURST_LSB = 8; // 5-bit burst length in words
  localparam int CFG_FLUSH_BIT = 15; // flush both fifos
  localparam int DPC_SKIP_BIT = 31; // rx_skip_packet
  localparam int MAC_EN_BIT = 0; // receiver_enable_bit
  localparam int MAC_HALT_BIT = 1; // receiver halted, read only
  localparam int ERR_FLAG_BIT = 0; // sticky, write one to clear
  localparam int FILL_STAT_LSB = 16; // status count field
  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int ST_FILT_BIT = 30;
  localparam int ST_LEN_LSB = 16;
  localparam int ST_ERRSUM_BIT = 15; // error_summary
  localparam int ST_RUNT_BIT = 11;
  localparam int ST_LONG_BIT = 7;
  localparam int ST_LATE_BIT = 6;
  localparam int ST_CRC_BIT = 1;
  localparam logic [13:0] ST_KEEP_MASK = 14'h3C7E; // drops 9,8,7,0
  localparam logic [13:0] MAX_FRAME_LEN = 14'h05EE; // 1518 bytes
  localparam logic [2:0] WORD_BYTES = 3'h4;
  // ----------------------------------------
  // write side states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_DATA = 5'h04,
    ST_TAIL = 5'h08,
    ST_PAD = 5'h10
  } erfhp_state_type;
endpackage

// File: hdl/erfhp_rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module erfhp_rx_fifo #(
  parameter int DDEPTH = 16, // data fifo words
  parameter int SDEPTH = 4 // status fifo words
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // mac_interface_layer side
  input wire logic i_mac_valid,
  input wire logic [31:0] i_mac_data,
  input wire logic i_mac_last,
  input wire logic [1:0] i_mac_nbytes,
  input wire logic [13:0] i_mac_len,
  input wire logic i_mac_filter_fail,
  input wire logic [13:0] i_mac_flags,
  output logic o_mac_ready,
  // events
  output logic o_receive_error_flag,
  output logic o_receiver_halted_event
);
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DAW = $clog2(DDEPTH);
  localparam int SAW = $clog2(SDEPTH);
  localparam logic [DAW:0] D_FULL = (DAW+1)'(DDEPTH);
  localparam logic [SAW:0] S_FULL = (SAW+1)'(SDEPTH);

  // ----------------------------------------
  // state of the block
  // ----------------------------------------
  typedef struct packed {
    erfhp_pkg::erfhp_state_type st; // write side state
    logic [1:0] sh; // byte shift of current packet
    logic [2:0] lead; // leading filler words left
    logic [31:0] carry; // bytes pushed out by the shift
    logic [4:0] bc; // words in packet modulo burst
    logic [31:0] stat; // status of packet in flight
    logic [DDEPTH-1:0][31:0] mem; // data storage
    logic [DAW:0] wr; // data write pointer
    logic [DAW:0] rd; // data read pointer
    logic [SDEPTH-1:0][31:0] smem; // status storage
    logic [SAW:0] swr;
    logic [SAW:0] srd;
    logic [SDEPTH-1:0][DAW:0] bnd; // packet end pointers
    logic [SAW:0] bwr;
    logic [SAW:0] brd;
    logic [4:0] ofs; // start offset in bytes
    logic pad_en;
    logic [4:0] burst; // burst length in words
    logic flush;
    logic skip;
    logic rx_en;
    logic halted;
    logic halt_ev;
    logic err;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic ready;
  } erfhp_regs_type;

  erfhp_regs_type r_q; // registered state
  erfhp_regs_type r_d; // next state

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  logic acc; // access phase, answer not given yet
  logic done; // access phase completing now
  logic [DAW:0] used; // data words queued
  logic [SAW:0] scnt; // status words queued
  logic [SAW:0] bcnt; // complete packets queued
  logic space; // room for one data word
  logic push; // store a data word
  logic [31:0] pdata; // word to store
  logic [63:0] w64; // shifted input with carry
  logic [2:0] nb; // valid bytes in last word
  logic [31:0] stw; // status word under build
  logic [DAW:0] used_n; // fill after this cycle

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    w64 = 64'h0;
    nb = 3'h0;
    stw = 32'h0;
    push = 1'b0;
    pdata = 32'h0;
    used_n = '0;
    used = r_q.wr - r_q.rd;
    scnt = r_q.swr - r_q.srd;
    bcnt = r_q.bwr - r_q.brd;
    space = (used < D_FULL);
    acc = i_psel & i_penable & ~r_q.pready;
    done = i_psel & i_penable & r_q.pready;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    r_d.halt_ev = 1'b0;

    // writes land on the edge that sees pready high
    if (done && i_pwrite) begin
      case (i_paddr)
        erfhp_pkg::ADDR_RX_CFG: begin
          r_d.ofs = i_pwdata[erfhp_pkg::CFG_OFS_LSB +: 5];
          r_d.pad_en = i_pwdata[erfhp_pkg::CFG_PAD_BIT];
          r_d.burst = i_pwdata[erfhp_pkg::CFG_BURST_LSB +: 5];
          if (i_pwdata[erfhp_pkg::CFG_FLUSH_BIT]) begin
            r_d.flush = 1'b1;
          end
        end
        erfhp_pkg::ADDR_DP_CTRL: begin
          // only a one starts a skip; hardware ends it
          if (i_pwdata[erfhp_pkg::DPC_SKIP_BIT]) begin
            r_d.skip = 1'b1;
          end
        end
        erfhp_pkg::ADDR_MAC_CTRL: begin
          r_d.rx_en = i_pwdata[erfhp_pkg::MAC_EN_BIT];
        end
        erfhp_pkg::ADDR_ERR: begin
          // clear first, so a set later in this process wins
          if (i_pwdata[erfhp_pkg::ERR_FLAG_BIT]) begin
            r_d.err = 1'b0;
          end
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // answer prepared one cycle into the access phase
    if (acc) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0;
      case (i_paddr)
        erfhp_pkg::ADDR_RX_DATA: begin
          if (!i_pwrite) begin
            if (used == '0) begin
              r_d.err = 1'b1;
            end else begin
              // whole word per access keeps the pair atomic
              r_d.prdata = r_q.mem[r_q.rd[DAW-1:0]];
              r_d.rd = r_q.rd + 1'b1;
              // crossing a packet end retires its boundary
              if (bcnt != '0 && r_d.rd == r_q.bnd[r_q.brd[SAW-1:0]]) begin
                r_d.brd = r_q.brd + 1'b1;
              end
            end
          end
        end
        erfhp_pkg::ADDR_RX_STAT: begin
          if (!i_pwrite) begin
            // own pointers, so status may run ahead of data
            if (scnt == '0) begin
              r_d.err = 1'b1;
            end else begin
              r_d.prdata = r_q.smem[r_q.srd[SAW-1:0]];
              r_d.srd = r_q.srd + 1'b1;
            end
          end
        end
        erfhp_pkg::ADDR_FILL: begin
          r_d.prdata[15:0] = 16'(used);
          r_d.prdata[erfhp_pkg::FILL_STAT_LSB +: 8] = 8'(scnt);
        end
        erfhp_pkg::ADDR_RX_CFG: begin
          r_d.prdata[erfhp_pkg::CFG_OFS_LSB +: 5] = r_q.ofs;
          r_d.prdata[erfhp_pkg::CFG_PAD_BIT] = r_q.pad_en;
          r_d.prdata[erfhp_pkg::CFG_BURST_LSB +: 5] = r_q.burst;
          r_d.prdata[erfhp_pkg::CFG_FLUSH_BIT] = r_q.flush;
        end
        erfhp_pkg::ADDR_DP_CTRL: begin
          r_d.prdata[erfhp_pkg::DPC_SKIP_BIT] = r_q.skip;
        end
        erfhp_pkg::ADDR_MAC_CTRL: begin
          r_d.prdata[erfhp_pkg::MAC_EN_BIT] = r_q.rx_en;
          r_d.prdata[erfhp_pkg::MAC_HALT_BIT] = r_q.halted;
        end
        erfhp_pkg::ADDR_ERR: begin
          r_d.prdata[erfhp_pkg::ERR_FLAG_BIT] = r_q.err;
        end
        default: begin
          r_d.pslverr = 1'b1; // unmapped address
        end
      endcase
    end
    // halt is seen only between frames
    if (r_q.rx_en) begin
      r_d.halted = 1'b0;
    end else if (r_q.st == erfhp_pkg::ST_IDLE && !r_q.halted) begin
      r_d.halted = 1'b1;
      r_d.halt_ev = 1'b1;
    end
    // status word for the packet ending now
    stw[erfhp_pkg::ST_FILT_BIT] = i_mac_filter_fail;
    stw[erfhp_pkg::ST_LEN_LSB +: 14] = i_mac_len;
    stw[13:0] = i_mac_flags & erfhp_pkg::ST_KEEP_MASK;
    // long frames are flagged, never cut short
    stw[erfhp_pkg::ST_LONG_BIT] = (i_mac_len > erfhp_pkg::MAX_FRAME_LEN);
    stw[erfhp_pkg::ST_ERRSUM_BIT] = stw[erfhp_pkg::ST_RUNT_BIT] |
                                stw[erfhp_pkg::ST_LONG_BIT] |
                                stw[erfhp_pkg::ST_LATE_BIT] |
                                stw[erfhp_pkg::ST_CRC_BIT];
    // write side sequencer
    case (r_q.st)
      erfhp_pkg::ST_IDLE: begin
        // offset latched once, so mid-packet edits cannot tear it
        if (r_q.rx_en && i_mac_valid) begin
          r_d.sh = r_q.ofs[1:0];
          r_d.lead = r_q.ofs[4:2];
          r_d.carry = 32'h0;
          r_d.bc = 5'h00;
          r_d.st = erfhp_pkg::ST_LEAD;
        end
      end
      erfhp_pkg::ST_LEAD: begin
        // whole filler words for the offset
        if (r_q.lead == 3'h0) begin
          r_d.st = erfhp_pkg::ST_DATA;
        end else if (space) begin
          push = 1'b1;
          r_d.lead = r_q.lead - 3'h1;
        end
      end
      erfhp_pkg::ST_DATA: begin
        if (i_mac_valid && r_q.ready) begin
          w64 = ({32'h0, i_mac_data} << {r_q.sh, 3'b000}) | {32'h0, r_q.carry};
          push = 1'b1;
          pdata = w64[31:0];
          r_d.carry = w64[63:32];
          if (i_mac_last) begin
            nb = (i_mac_nbytes == 2'h0) ? erfhp_pkg::WORD_BYTES : {1'b0, i_mac_nbytes};
            r_d.stat = stw;
            // shifted bytes spill into one extra word
            if (({1'b0, r_q.sh} + nb) > erfhp_pkg::WORD_BYTES) begin
              r_d.st = erfhp_pkg::ST_TAIL;
            end else begin
              r_d.st = erfhp_pkg::ST_PAD;
            end
          end
        end
      end
      erfhp_pkg::ST_TAIL: begin
        if (space) begin
          push = 1'b1;
          pdata = r_q.carry;
          r_d.st = erfhp_pkg::ST_PAD;
        end
      end
      erfhp_pkg::ST_PAD: begin
        if (!r_q.pad_en || r_q.burst == 5'h00 || r_q.bc == 5'h00) begin
          // packet closed: status after its data
          if (scnt == S_FULL || bcnt == S_FULL) begin
            r_d.err = 1'b1;
          end else begin
            r_d.smem[r_q.swr[SAW-1:0]] = r_q.stat;
            r_d.swr = r_q.swr + 1'b1;
            r_d.bnd[r_q.bwr[SAW-1:0]] = r_q.wr;
            r_d.bwr = r_q.bwr + 1'b1;
          end
          r_d.st = erfhp_pkg::ST_IDLE;
        end else if (space) begin
          push = 1'b1;
        end
      end
      default: begin
        r_d.st = erfhp_pkg::ST_IDLE;
      end
    endcase
    // store a word and track burst alignment
    if (push) begin
      r_d.mem[r_q.wr[DAW-1:0]] = pdata;
      r_d.wr = r_q.wr + 1'b1;
      r_d.bc = (r_q.bc + 5'h01 == r_q.burst) ? 5'h00 : r_q.bc + 5'h01;
    end
    // skip waits until a whole packet is queued
    if (r_q.skip && bcnt != '0) begin
      r_d.rd = r_q.bnd[r_q.brd[SAW-1:0]];
      r_d.brd = r_q.brd + 1'b1;
      r_d.skip = 1'b0;
    end
    // flush overrides the pointer, skip and state updates made this cycle
    if (r_q.flush) begin
      r_d.wr = '0;
      r_d.rd = '0;
      r_d.swr = '0;
      r_d.srd = '0;
      r_d.bwr = '0;
      r_d.brd = '0;
      r_d.carry = 32'h0;
      r_d.skip = 1'b0;
      r_d.st = erfhp_pkg::ST_IDLE;
      r_d.flush = 1'b0;
    end
    // ready only in data phase, one word of headroom
    used_n = r_d.wr - r_d.rd;
    r_d.ready = (r_d.st == erfhp_pkg::ST_DATA) && (used_n < D_FULL - 1'b1);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_q <= '0;
      r_q.st <= erfhp_pkg::ST_IDLE;
      r_q.halted <= 1'b1; // no event for the reset halt
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign o_pready = r_q.pready;
  assign o_prdata = r_q.prdata;
  assign o_pslverr = r_q.pslverr;
  assign o_mac_ready = r_q.ready;
  assign o_receive_error_flag = r_q.err;
  assign o_receiver_halted_event = r_q.halt_ev;
endmodule // erfhp_rx_fifo
`default_nettype wire

// File: test/erfhp_rx_fifo_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the receive fifo block
// ----------------------------------------
module erfhp_rx_fifo_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // mac side and events
  input wire logic o_mac_ready,
  input wire logic o_receive_error_flag,
  input wire logic o_receiver_halted_event
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // answer to a status port read
  logic st_rd;
  // address inside the seven word map
  logic mapped;
  assign st_rd = o_pready && !i_pwrite && i_paddr == erfhp_pkg::ADDR_RX_STAT;
  assign mapped = i_paddr <= erfhp_pkg::ADDR_ERR && i_paddr[1:0] == 2'h0;
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  chk_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer not after one wait state");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  chk_unmapped_err: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("slave error does not match map");
  chk_stat_reserved: assert property (st_rd |-> !o_prdata[31] && !o_prdata[14])
    else $error("reserved status bit set");
  chk_err_summary: assert property (st_rd |->
    o_prdata[15] == |{o_prdata[11], o_prdata[7], o_prdata[6], o_prdata[1]})
    else $error("error summary wrong");
  chk_long_frame: assert property (st_rd |->
    o_prdata[7] == (o_prdata[29:16] > erfhp_pkg::MAX_FRAME_LEN))
    else $error("long frame bit wrong");
  // the sticky flag only drops on a completed write of one to its bit
  chk_err_clear: assert property ($fell(o_receive_error_flag) |->
    $past(i_psel && i_penable && o_pready && i_pwrite && i_pwdata[0]
    && i_paddr == erfhp_pkg::ADDR_ERR))
    else $error("error flag dropped without clear");
  chk_halt_pulse: assert property ($rose(o_receiver_halted_event) |=>
    !o_receiver_halted_event && !o_mac_ready)
    else $error("halt event not a single pulse");
  cov_stat_read: cover property (st_rd);
  cov_halt: cover property (o_receiver_halted_event);
  cov_err: cover property ($rose(o_receive_error_flag));
endmodule // erfhp_rx_fifo_chk
bind erfhp_rx_fifo erfhp_rx_fifo_chk chk_u (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_mac_ready(o_mac_ready),
  .o_receive_error_flag(o_receive_error_flag),
  .o_receiver_halted_event(o_receiver_halted_event)
);
`default_nettype wire

// File: test/erfhp_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// mac_interface_layer word source
// ----------------------------------------
module erfhp_mac_model (
  // clock
  input wire logic i_clk,
  // word handshake
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data,
  output logic o_last,
  // frame status, qualified by last
  output logic [1:0] o_nbytes,
  output logic [13:0] o_len,
  output logic o_filter_fail,
  output logic [13:0] o_flags
);
  // idle values; nbytes stays 0, so every word is full
  initial begin
    o_valid = 1'b0;
    o_data = 32'h5A5A5A5A;
    o_last = 1'b0;
    o_nbytes = 2'h0;
    o_len = 14'h0;
    o_filter_fail = 1'b0;
    o_flags = 14'h0;
  end
  // n words base, base+1 ...; a word stands until valid and ready meet
  task automatic send(input int n, input logic [31:0] base, input logic [13:0] fl,
                      input logic ff, output int got);
    int k;
    int t;
    k = 0;
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_data <= base;
    o_last <= n == 1;
    o_len <= 14'(4 * n);
    o_filter_fail <= ff;
    o_flags <= fl;
    for (t = 0; t < 300 && k < n; t++) begin
      @(posedge i_clk);
      if (i_ready === 1'b1) begin
        k++;
        // released data shows the inverse, never a stale word
        o_data <= (k == n) ? ~o_data : base + 32'(k);
        o_valid <= k < n;
        o_last <= k == n - 1;
      end
    end
    // words taken; short of n means the block stalled
    got = k;
  endtask
endmodule // erfhp_mac_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fail_count++; \
  $display("[ERR] %0t got %h expected %h", $time, g, x); end end
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, mvalid, mlast, mready, mff, err_flag, halt_ev;
  logic [31:0] prdata, mdata, d;
  logic [1:0] mnb;
  logic [13:0] mlen, mflags;
  logic e;
  int fail_count = 0;
  int compares = 0;
  always #10 i_clk = ~i_clk;
  erfhp_rx_fifo #(.DDEPTH(16), .SDEPTH(4)) dut_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_mac_valid(mvalid), .i_mac_data(mdata),
    .i_mac_last(mlast), .i_mac_nbytes(mnb), .i_mac_len(mlen), .i_mac_filter_fail(mff),
    .i_mac_flags(mflags), .o_mac_ready(mready), .o_receive_error_flag(err_flag),
    .o_receiver_halted_event(halt_ev));
  erfhp_mac_model mac_u (
    .i_clk(i_clk), .i_ready(mready), .o_valid(mvalid), .o_data(mdata), .o_last(mlast),
    .o_nbytes(mnb), .o_len(mlen), .o_filter_fail(mff), .o_flags(mflags));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset held six edges; also the host soft reset
  task automatic reset();
    i_arst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
  endtask
  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (t == 20) begin
      fail_count++;
      conclude();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded poll of one register bit
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int t;
    for (t = 0; t < 30; t++) begin
      apb(0, a, 0);
      if (d[b] === v) break;
    end
    `CHK(d[b], v)
    if (t == 30) conclude();
  endtask
  // one frame from the mac model; a stalled frame ends the run
  task automatic feed(input int n, input logic [31:0] base, input logic [13:0] fl,
                      input logic ff);
    int got;
    mac_u.send(n, base, fl, ff, got);
    if (got != n) begin
      fail_count++;
      conclude();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // one frame: status read ahead of data, then an unmapped word
  task automatic t_frame();
    int k;
    apb(0, erfhp_pkg::ADDR_MAC_CTRL, 0);
    `CHK(d[1:0], 2'h2)
    apb(1, erfhp_pkg::ADDR_MAC_CTRL, 32'h1);
    feed(3, 32'hA0, 14'h2882, 1'b1);
    poll(erfhp_pkg::ADDR_FILL, 16, 1'b1);
    `CHK(d, 32'h00010003)
    apb(0, erfhp_pkg::ADDR_RX_STAT, 0);
    `CHK(d, 32'h400CA802)
    for (k = 0; k < 3; k++) begin
      apb(0, erfhp_pkg::ADDR_RX_DATA, 0);
      `CHK(d, 32'hA0 + 32'(k))
    end
    apb(0, 8'h1C, 0);
    `CHK({e, d}, 33'h100000000)
    $display("t_frame done");
  endtask
  // underrun of both fifos, clear, status overrun, soft reset
  task automatic t_errors();
    int k;
    apb(0, erfhp_pkg::ADDR_RX_DATA, 0);
    `CHK(d, 32'h0)
    apb(0, erfhp_pkg::ADDR_RX_STAT, 0);
    `CHK(d, 32'h0)
    apb(0, erfhp_pkg::ADDR_ERR, 0);
    `CHK({err_flag, d[0]}, 2'h3)
    apb(1, erfhp_pkg::ADDR_ERR, 32'h1);
    apb(0, erfhp_pkg::ADDR_ERR, 0);
    `CHK({err_flag, d[0]}, 2'h0)
    for (k = 0; k < 5; k++) feed(1, 32'hD0, 14'h0, 1'b0);
    poll(erfhp_pkg::ADDR_FILL, 18, 1'b1);
    poll(erfhp_pkg::ADDR_ERR, 0, 1'b1);
    reset();
    $display("t_errors done");
  endtask
  // offset and padding per packet, skip, halt and flush
  task automatic t_skip_flush();
    int k;
    apb(1, erfhp_pkg::ADDR_RX_CFG, 32'h484);
    apb(1, erfhp_pkg::ADDR_MAC_CTRL, 32'h1);
    feed(2, 32'hB0, 14'h0, 1'b0);
    feed(4, 32'hC0, 14'h0, 1'b0);
    poll(erfhp_pkg::ADDR_FILL, 17, 1'b1);
    `CHK(d, 32'h0002000C)
    apb(0, erfhp_pkg::ADDR_RX_STAT, 0);
    `CHK(d, 32'h00080000)
    for (k = 0; k < 4; k++) begin
      apb(0, erfhp_pkg::ADDR_RX_DATA, 0);
      `CHK(d, (k == 0 || k == 3) ? 32'h0 : 32'hAF + 32'(k))
    end
    apb(1, erfhp_pkg::ADDR_DP_CTRL, 32'h80000000);
    poll(erfhp_pkg::ADDR_DP_CTRL, 31, 1'b0);
    apb(0, erfhp_pkg::ADDR_FILL, 0);
    `CHK(d, 32'h00010000)
    apb(1, erfhp_pkg::ADDR_MAC_CTRL, 0);
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (halt_ev === 1'b1) break;
    end
    `CHK(halt_ev, 1'b1)
    if (k == 20) conclude();
    apb(1, erfhp_pkg::ADDR_RX_CFG, 32'h8000);
    poll(erfhp_pkg::ADDR_RX_CFG, 15, 1'b0);
    apb(0, erfhp_pkg::ADDR_FILL, 0);
    `CHK(d, 32'h0)
    $display("t_skip_flush done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset();
    t_frame();
    t_errors();
    t_skip_flush();
    conclude();
  end
endmodule // testbench
`default_nettype wire
